// ==== design/sqa_pkg.sv ====
package sqa_pkg;
   localparam int GRADE_W = 2;
   localparam int LIN_N = 2;
   localparam int DPM_N = 7;
   localparam int PAIR_W = 3;
   localparam int SRC_W = 4;
   localparam int PPE_W = 8;

   // Grade codes: larger is better
   localparam logic [1:0] GRADE_D = 2'h0;
   localparam logic [1:0] GRADE_C = 2'h1;
   localparam logic [1:0] GRADE_B = 2'h2;
   localparam logic [1:0] GRADE_A = 2'h3;

   // Output source selection codes: the quality alarm source and the reset default
   localparam logic [3:0] SRC_SYMBOL_QUALITY = 4'h5;
   localparam logic [3:0] SRC_RESET = 4'h0;

   // Least resolution for part-mark grading, tenths of a pixel per element
   localparam logic [7:0] MIN_PPE_X10 = 8'h3C;

   // Register byte offsets
   localparam logic [7:0] OFS_SRC = 8'h00;
   localparam logic [7:0] OFS_LIN = 8'h04;
   localparam logic [7:0] OFS_DPM = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // Each pair: enable at bit PAIR_W*i, threshold at PAIR_W*i+1
   localparam int EN_POS = 0;
   localparam int THR_POS = 1;
   localparam logic [5:0] LIN_RESET = 6'h24;
   localparam logic [20:0] DPM_RESET = 21'h124924;

   // Status fields
   localparam int ST_ALARM = 0;
   localparam int ST_LIN = 1;
   localparam int ST_DPM = 3;
   localparam int ST_GRADED = 10;

   typedef struct packed {
      logic lin_valid;
      logic [LIN_N-1:0][GRADE_W-1:0] lin_grade;
      logic dpm_valid;
      logic dpm_matrix;
      logic [PPE_W-1:0] ppe_x10;
      logic [DPM_N-1:0][GRADE_W-1:0] dpm_grade;
   } sqa_result_t;

   typedef struct packed {
      logic lin_have;
      logic [LIN_N-1:0][GRADE_W-1:0] lin_grade;
      logic dpm_graded;
      logic [DPM_N-1:0][GRADE_W-1:0] dpm_grade;
   } sqa_held_t;
endpackage

// ==== design/sqa_alarm.sv ====
// The register addresses and register access over APB were left to the implementer.
module sqa_alarm (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sqa_pkg::sqa_result_t result,
   input wire logic other_src_level,
   output logic out1,
   output logic alarm
);
   function automatic logic pair_below(input logic en, input logic [1:0] thr, input logic [1:0] grade);
      pair_below = en && (grade < thr);
   endfunction

   logic [3:0] src, next_src;
   logic [5:0] lin_cfg, next_lin_cfg;
   logic [20:0] dpm_cfg, next_dpm_cfg;
   sqa_pkg::sqa_held_t held, next_held;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_out1, next_alarm;
   logic [8:0] below;
   logic access, wr, mapped, graded_now;

   // Register file, one wait state per access
   assign access = psel && penable && !pready;
   assign wr = psel && penable && pready && pwrite && !pslverr;
   assign mapped = (paddr == sqa_pkg::OFS_SRC) || (paddr == sqa_pkg::OFS_LIN) ||
                   (paddr == sqa_pkg::OFS_DPM) || (paddr == sqa_pkg::OFS_STATUS);

   always_comb begin
      next_src = src;
      next_lin_cfg = lin_cfg;
      next_dpm_cfg = dpm_cfg;
      next_pready = access;
      next_pslverr = access && !mapped;
      next_prdata = prdata;
      if (wr) begin
         case (paddr)
            sqa_pkg::OFS_SRC: next_src = pwdata[3:0];
            sqa_pkg::OFS_LIN: next_lin_cfg = pwdata[5:0];
            sqa_pkg::OFS_DPM: next_dpm_cfg = pwdata[20:0];
            default: next_src = src;
         endcase
      end
      if (access && !pwrite) begin
         case (paddr)
            sqa_pkg::OFS_SRC: next_prdata = {28'h0000000, src};
            sqa_pkg::OFS_LIN: next_prdata = {26'h0000000, lin_cfg};
            sqa_pkg::OFS_DPM: next_prdata = {11'h000, dpm_cfg};
            sqa_pkg::OFS_STATUS: next_prdata = {21'h000000, held.dpm_graded, below, alarm};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   // Result capture; ungraded part-mark results keep their grades but raise no conditions
   assign graded_now = result.dpm_matrix && (result.ppe_x10 >= sqa_pkg::MIN_PPE_X10);

   always_comb begin
      next_held = held;
      if (result.lin_valid) begin
         next_held.lin_have = 1'b1;
         next_held.lin_grade = result.lin_grade;
      end
      if (result.dpm_valid) begin
         next_held.dpm_graded = graded_now;
         next_held.dpm_grade = result.dpm_grade;
      end
   end

   // Per-metric comparison
   genvar gi;
   generate
      for (gi = 0; gi < sqa_pkg::LIN_N; gi++) begin : g_lin
         assign below[gi] = held.lin_have && pair_below(lin_cfg[sqa_pkg::PAIR_W*gi+sqa_pkg::EN_POS],
            lin_cfg[sqa_pkg::PAIR_W*gi+sqa_pkg::THR_POS +: 2], held.lin_grade[gi]);
      end
      for (gi = 0; gi < sqa_pkg::DPM_N; gi++) begin : g_dpm
         assign below[sqa_pkg::LIN_N+gi] = held.dpm_graded &&
            pair_below(dpm_cfg[sqa_pkg::PAIR_W*gi+sqa_pkg::EN_POS],
            dpm_cfg[sqa_pkg::PAIR_W*gi+sqa_pkg::THR_POS +: 2], held.dpm_grade[gi]);
      end
   endgenerate

   always_comb begin
      next_alarm = |below;
      next_out1 = (src == sqa_pkg::SRC_SYMBOL_QUALITY) ? alarm : other_src_level;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src <= sqa_pkg::SRC_RESET;
         lin_cfg <= sqa_pkg::LIN_RESET;
         dpm_cfg <= sqa_pkg::DPM_RESET;
         held <= '0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         alarm <= 1'b0;
         out1 <= 1'b0;
      end else begin
         src <= next_src;
         lin_cfg <= next_lin_cfg;
         dpm_cfg <= next_dpm_cfg;
         held <= next_held;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         alarm <= next_alarm;
         out1 <= next_out1;
      end
   end

   // Checks
   logic fresh;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   property p_lin_rst;
      @(posedge pclk) disable iff (!presetn)
      fresh |-> (lin_cfg[2:1] == sqa_pkg::GRADE_B) && (lin_cfg[5:4] == sqa_pkg::GRADE_B);
   endproperty
   a_lin_rst: assert property (p_lin_rst) else $error("linear thresholds not grade B after reset");

   property p_dpm_rst;
      @(posedge pclk) disable iff (!presetn)
      fresh |-> (dpm_cfg[2:1] == sqa_pkg::GRADE_B) && (dpm_cfg[20:19] == sqa_pkg::GRADE_B);
   endproperty
   a_dpm_rst: assert property (p_dpm_rst) else $error("part-mark thresholds not grade B after reset");

   property p_en_rst;
      @(posedge pclk) disable iff (!presetn)
      fresh |-> !lin_cfg[0] && !lin_cfg[3] && !dpm_cfg[0] && !dpm_cfg[18] ##1 !alarm;
   endproperty
   a_en_rst: assert property (p_en_rst) else $error("enables not cleared after reset");

   property p_grade_d;
      @(posedge pclk) disable iff (!presetn)
      (lin_cfg[2:1] == sqa_pkg::GRADE_D) |-> !below[0];
   endproperty
   a_grade_d: assert property (p_grade_d) else $error("grade D threshold raised a condition");

   property p_decod;
      @(posedge pclk) disable iff (!presetn)
      held.lin_have && lin_cfg[0] && (held.lin_grade[0] < lin_cfg[2:1]) |=> alarm;
   endproperty
   a_decod: assert property (p_decod) else $error("decodability below threshold without alarm");

   property p_qz;
      @(posedge pclk) disable iff (!presetn)
      held.lin_have && !lin_cfg[3] |-> !below[1];
   endproperty
   a_qz: assert property (p_qz) else $error("disabled quiet zone raised a condition");

   property p_ecc;
      @(posedge pclk) disable iff (!presetn)
      held.dpm_graded && dpm_cfg[18] && (held.dpm_grade[6] < dpm_cfg[20:19]) |=> alarm;
   endproperty
   a_ecc: assert property (p_ecc) else $error("unused capacity below threshold without alarm");

   property p_pin;
      @(posedge pclk) disable iff (!presetn)
      (src == sqa_pkg::SRC_SYMBOL_QUALITY) |=> (out1 == $past(alarm));
   endproperty
   a_pin: assert property (p_pin) else $error("output 1 not following the alarm");

   property p_other;
      @(posedge pclk) disable iff (!presetn)
      (src != sqa_pkg::SRC_SYMBOL_QUALITY) |=> (out1 == $past(other_src_level));
   endproperty
   a_other: assert property (p_other) else $error("alarm affected output 1 under another source");

   property p_ungraded;
      @(posedge pclk) disable iff (!presetn)
      result.dpm_valid && (result.ppe_x10 < sqa_pkg::MIN_PPE_X10) |=> !held.dpm_graded ##0 (below[8:2] == 7'h00);
   endproperty
   a_ungraded: assert property (p_ungraded) else $error("low resolution result was graded");

   property p_or;
      @(posedge pclk) disable iff (!presetn)
      (below == 9'h000) |=> !alarm;
   endproperty
   a_or: assert property (p_or) else $error("alarm without any condition");

   property p_wait;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_wait: assert property (p_wait) else $error("access not answered after one wait state");

   c_alarm: cover property (@(posedge pclk) disable iff (!presetn) $rose(alarm));
   c_pin: cover property (@(posedge pclk) disable iff (!presetn) $rose(out1) && (src == sqa_pkg::SRC_SYMBOL_QUALITY));
   c_ungraded: cover property (@(posedge pclk) disable iff (!presetn) result.dpm_valid && !graded_now);
   c_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

// ==== testbench/sqa_plc_model.sv ====
module sqa_plc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic out1,
   output logic level,
   output int rises
);
   timeunit 1ns;
   timeprecision 1ns;
   // Relay input latches the pin each clock and counts activations
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
         rises <= 0;
      end else begin
         if (out1 && !level) rises <= rises + 1;
         level <= out1;
      end
   end
endmodule

// ==== testbench/symbol_quality_alarm_output_tb.sv ====
module symbol_quality_alarm_output_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, other_src_level;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, out1, alarm, er, plc_level;
   sqa_pkg::sqa_result_t result;
   int num_errors = 0;
   int tests_run = 0;
   int plc_rises;
   sqa_alarm sqa_alarm_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .result(result),
      .other_src_level(other_src_level), .out1(out1), .alarm(alarm));
   sqa_plc_model sqa_plc_model_i (.pclk(pclk), .presetn(presetn), .out1(out1), .level(plc_level),
      .rises(plc_rises));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic res(input logic lv, input logic dv, input logic [3:0] lg, input logic [13:0] dg,
      input logic [7:0] ppe);
      @(posedge pclk);
      result.lin_valid <= lv;
      result.dpm_valid <= dv;
      result.dpm_matrix <= 1'b1;
      result.lin_grade <= lg;
      result.dpm_grade <= dg;
      result.ppe_x10 <= ppe;
      @(posedge pclk);
      result.lin_valid <= 1'b0;
      result.dpm_valid <= 1'b0;
      repeat (5) @(posedge pclk);
   endtask
   task automatic t_reset;
      apb(1'b0, sqa_pkg::OFS_LIN, 32'h0);
      chk(rd, 32'h00000024, "linear reset");
      apb(1'b0, sqa_pkg::OFS_DPM, 32'h0);
      chk(rd, 32'h00124924, "part-mark reset");
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped read");
   endtask
   task automatic t_lin;
      apb(1'b1, sqa_pkg::OFS_SRC, 32'h5);
      apb(1'b1, sqa_pkg::OFS_LIN, 32'h05);
      res(1'b1, 1'b0, {2'h3, 2'h1}, 14'h3FFF, 8'h3C);
      chk({alarm, plc_level}, 2'b11, "decodability C below B");
      res(1'b1, 1'b0, {2'h3, 2'h2}, 14'h3FFF, 8'h3C);
      chk(alarm, 1'b0, "grade equal to threshold");
      apb(1'b1, sqa_pkg::OFS_LIN, 32'h38);
      chk(alarm, 1'b0, "quiet zone A at A");
      res(1'b1, 1'b0, {2'h2, 2'h0}, 14'h3FFF, 8'h3C);
      chk(alarm, 1'b1, "quiet zone B below A");
   endtask
   task automatic t_dpm;
      apb(1'b1, sqa_pkg::OFS_LIN, 32'h24);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, sqa_pkg::OFS_DPM, 32'h00124924 | (32'h1 << (3 * i)));
         chk(alarm, 1'b0, "other metric disabled");
         res(1'b0, 1'b1, 4'hF, 14'h3FFF & ~(14'h2 << (2 * i)), 8'h3C);
         chk(alarm, 1'b1, "part-mark metric below");
      end
      res(1'b0, 1'b1, 4'hF, 14'h0, 8'h3B);
      chk(alarm, 1'b0, "low resolution not graded");
      apb(1'b1, sqa_pkg::OFS_LIN, 32'h38);
      chk(alarm, 1'b1, "linear joins alarm");
      res(1'b0, 1'b1, 4'hF, 14'h0FFF, 8'h3C);
      apb(1'b1, sqa_pkg::OFS_LIN, 32'h24);
      chk(alarm, 1'b1, "part-mark keeps alarm after linear off");
      apb(1'b0, sqa_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h00000601, "status with unused capacity below");
   endtask
   task automatic t_src;
      apb(1'b1, sqa_pkg::OFS_SRC, 32'h0);
      chk(plc_level, 1'b0, "alarm masked by source");
      other_src_level <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(plc_level, 1'b1, "other source drives pin");
      chk(plc_rises > 0, 1'b1, "relay saw activation");
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      end_sim();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      other_src_level = 1'b0;
      result = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_lin();
      t_dpm();
      t_src();
      end_sim();
   end
endmodule
